// File: pkg/cbfa_alu_map.vh
// instruction fields and encodings of the custom alu
`ifndef CBFA_ALU_MAP_VH
`define CBFA_ALU_MAP_VH

// ========
// instruction word fields
`define CBFA_F_OPC 6:0
`define CBFA_F_F3 14:12
`define CBFA_F_F7 31:25
`define CBFA_F_SEL2 31:30
`define CBFA_F_WIDTH 29:25
`define CBFA_F_WIDTH_HI 29:27
`define CBFA_F_OFFS 24:20
`define CBFA_F_RS2 24:20
`define CBFA_F_GROUP 1:0

// ========
// second-source field parameters
`define CBFA_B_WIDTH 9:5
`define CBFA_B_OFFS 4:0

// ========
// major opcodes and funct3
`define CBFA_OPC_IMM 7'h5b
`define CBFA_OPC_REG 7'h2b
`define CBFA_F3_EXTINS 3'h0
`define CBFA_F3_CLRSET 3'h1
`define CBFA_F3_ADDN 3'h2
`define CBFA_F3_SUBN 3'h3
`define CBFA_F3_REG 3'h3

// ========
// top two-bit selector values
`define CBFA_SEL_00 2'h0
`define CBFA_SEL_01 2'h1
`define CBFA_SEL_10 2'h2
`define CBFA_SEL_11 2'h3

// ========
// funct7 codes of the register group
`define CBFA_F7_SEXT_R 7'h18
`define CBFA_F7_ZEXT_R 7'h19
`define CBFA_F7_INS_R 7'h1a
`define CBFA_F7_CLR_R 7'h1c
`define CBFA_F7_SET_R 7'h1d
`define CBFA_F7_ROR 7'h20
`define CBFA_F7_FF1 7'h21
`define CBFA_F7_FL1 7'h22
`define CBFA_F7_CLB 7'h23
`define CBFA_F7_CNT 7'h24
`define CBFA_F7_ABS 7'h28
`define CBFA_F7_SLE 7'h29
`define CBFA_F7_SLEU 7'h2a
`define CBFA_F7_MIN 7'h2b
`define CBFA_F7_MINU 7'h2c
`define CBFA_F7_MAX 7'h2d
`define CBFA_F7_MAXU 7'h2e
`define CBFA_F7_EXTHS 7'h2f
`define CBFA_F7_EXTHZ 7'h30
`define CBFA_F7_EXTBS 7'h31
`define CBFA_F7_EXTBZ 7'h32
`define CBFA_F7_CLIP 7'h38
`define CBFA_F7_CLIPU 7'h39
`define CBFA_F7_CLIPR 7'h3a
`define CBFA_F7_CLIPUR 7'h3b

// ========
// field unit selectors
`define CBFA_FS_SEXT 3'h0
`define CBFA_FS_ZEXT 3'h1
`define CBFA_FS_INS 3'h2
`define CBFA_FS_CLR 3'h3
`define CBFA_FS_SET 3'h4
`define CBFA_FS_BREV 3'h5

// ========
// constants
`define CBFA_ZERO 32'h0000_0000
`define CBFA_ONE 32'h0000_0001
`define CBFA_RS2_ZERO 5'h00
`define CBFA_HI3_ZERO 3'h0
`define CBFA_MSB 5'h1f
`define CBFA_NONE 6'h20
`define CBFA_GRP_2 2'h1
`define CBFA_GRP_3 2'h2

`endif

// File: hdl/cbfa_field_unit.v
// bit-field extract, insert, clear, set and grouped bit reverse
`timescale 1ns/10ps
`include "cbfa_alu_map.vh"

module cbfa_field_unit (
    input wire [31:0] src_a,
    input wire [31:0] src_d,
    input wire [4:0] width_imm,
    input wire [4:0] offset_imm,
    input wire [2:0] fsel,
    output reg [31:0] result
);
    wire [5:0] hi_sum;
    wire [4:0] hi_bit, top_bit;
    wire [31:0] shifted, shl, mask, low_mask, rev1, rev2, rev3;
    wire sign_bit;

    // field end clamps at bit 31
    assign hi_sum = {1'b0, width_imm} + {1'b0, offset_imm};
    assign hi_bit = hi_sum[5] ? `CBFA_MSB : hi_sum[4:0];
    assign top_bit = hi_bit - offset_imm;
    assign shifted = src_a >> offset_imm;
    assign shl = src_a << offset_imm;
    assign sign_bit = shifted[top_bit];

    // ========
    // per-bit masks and reverse networks
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            localparam [4:0] IDX = i;
            localparam integer R2 = 30 - i + 2 * (i % 2);
            localparam integer R3 = 29 - 3 * (i / 3) + (i % 3);
            assign mask[i] = (IDX >= offset_imm) && (IDX <= hi_bit);
            assign low_mask[i] = (IDX <= top_bit);
            assign rev1[i] = shl[31 - i];
            assign rev2[i] = shl[R2];
            // radix-8 leaves the top two bits with no group
            if (i < 30) begin : g_r3
                assign rev3[i] = shl[R3];
            end else begin : g_r3z
                assign rev3[i] = 1'b0;
            end
        end
    endgenerate

    // ========
    // result select
    always @* begin
        case (fsel)
            `CBFA_FS_SEXT: result = (shifted & low_mask) | (sign_bit ? ~low_mask : `CBFA_ZERO);
            `CBFA_FS_ZEXT: result = shifted & low_mask;
            `CBFA_FS_INS: result = (src_d & ~mask) | (shl & mask);
            `CBFA_FS_CLR: result = src_a & ~mask;
            `CBFA_FS_SET: result = src_a | mask;
            `CBFA_FS_BREV: begin
                // group code 3 behaves as single-bit groups
                if (width_imm[`CBFA_F_GROUP] == `CBFA_GRP_2) begin
                    result = rev2;
                end else if (width_imm[`CBFA_F_GROUP] == `CBFA_GRP_3) begin
                    result = rev3;
                end else begin
                    result = rev1;
                end
            end
            default: result = `CBFA_ZERO;
        endcase
    end
endmodule

// File: hdl/cbfa_alu.v
// custom alu: decode and datapath for bit-field, general and normalise operations
//
// Operation
// - imm funct3 000: selector 00/01/10 = signed, unsigned extract, insert.
// - imm funct3 001: selector 00/01/11 = clear, set, grouped reverse.
// - reg funct7 18..1d: register-parameter extract, insert, clear, set.
// - absolute value negates a negative source.
// - set-less-or-equal gives 1 or 0, signed and unsigned.
// - minimum: first source if strictly less, else second.
// - maximum: second source if first strictly less, else first.
// - sign or zero extend low half-word or byte.
// - signed imm clip saturates to -2^(n-1) and 2^(n-1)-1.
// - imm zero gives bounds -1 and 0.
// - unsigned imm clip: non-positive gives 0, top 2^(n-1)-1.
// - signed reg clip bounds -(rs2+1) and rs2.
// - unsigned reg clip: non-positive gives 0, top rs2.
// - add, shift right: arithmetic signed, logical unsigned.
// - rounded add adds 2^(n-1) before the shift.
// - rounding term zero for zero shift.
// - subtract, shift right: arithmetic or logical.
// - rounded subtract adds 2^(n-1) before the shift.
// - signed extract extends from the field top bit.
// - clear/set keep bits outside the field.
// - find-last-one gives bit index, 32 for zero.
`timescale 1ns/10ps
`include "cbfa_alu_map.vh"

module cbfa_alu (
    input wire ref_clk,
    input wire reset,
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire [31:0] src_a,
    input wire [31:0] src_b,
    input wire [31:0] src_d,
    output wire result_valid,
    output wire [31:0] result_data,
    output wire illegal_instr
);
    // ========
    // operation codes
    localparam [4:0] OP_NONE = 5'h00,
        OP_FIELD_IMM = 5'h01,
        OP_FIELD_REG = 5'h02,
        OP_ROR = 5'h03,
        OP_FF1 = 5'h04,
        OP_FL1 = 5'h05,
        OP_CLB = 5'h06,
        OP_CNT = 5'h07,
        OP_ABS = 5'h08,
        OP_SLE = 5'h09,
        OP_SLEU = 5'h0a,
        OP_MIN = 5'h0b,
        OP_MINU = 5'h0c,
        OP_MAX = 5'h0d,
        OP_MAXU = 5'h0e,
        OP_EXTHS = 5'h0f,
        OP_EXTHZ = 5'h10,
        OP_EXTBS = 5'h11,
        OP_EXTBZ = 5'h12,
        OP_CLIP = 5'h13,
        OP_CLIPU = 5'h14,
        OP_CLIPR = 5'h15,
        OP_CLIPUR = 5'h16,
        OP_NORM = 5'h17;

    reg result_valid_reg;
    reg [31:0] result_data_reg;
    reg illegal_reg;
    reg [4:0] op_sel;
    reg [2:0] fsel;
    reg claim;
    reg bad;
    reg [31:0] alu_res;
    reg [5:0] ff1_cnt, fl1_cnt, clb_cnt, pop_cnt;
    reg clb_stop;
    integer k;

    wire [6:0] opc = instr_word[`CBFA_F_OPC];
    wire [2:0] f3 = instr_word[`CBFA_F_F3];
    wire [6:0] f7 = instr_word[`CBFA_F_F7];
    wire [1:0] sel2 = instr_word[`CBFA_F_SEL2];
    wire rs2_zero = (instr_word[`CBFA_F_RS2] == `CBFA_RS2_ZERO);
    wire [4:0] imm_w = instr_word[`CBFA_F_WIDTH];
    wire [4:0] imm_o = instr_word[`CBFA_F_OFFS];
    wire [31:0] field_res;
    wire [63:0] rot_dbl;
    wire lt_s, lt_u;
    wire [31:0] clip_pow, clip_hi, rnd_term, norm_sum, norm_res;

    // ========
    // decode
    always @* begin
        op_sel = OP_NONE;
        fsel = `CBFA_FS_SEXT;
        claim = 1'b0;
        bad = 1'b0;
        if (opc == `CBFA_OPC_IMM) begin
            claim = 1'b1;
            op_sel = OP_FIELD_IMM;
            case (f3)
                `CBFA_F3_EXTINS: begin
                    case (sel2)
                        `CBFA_SEL_00: fsel = `CBFA_FS_SEXT;
                        `CBFA_SEL_01: fsel = `CBFA_FS_ZEXT;
                        `CBFA_SEL_10: fsel = `CBFA_FS_INS;
                        default: bad = 1'b1;
                    endcase
                end
                `CBFA_F3_CLRSET: begin
                    case (sel2)
                        `CBFA_SEL_00: fsel = `CBFA_FS_CLR;
                        `CBFA_SEL_01: fsel = `CBFA_FS_SET;
                        `CBFA_SEL_11: begin
                            fsel = `CBFA_FS_BREV;
                            bad = (instr_word[`CBFA_F_WIDTH_HI] != `CBFA_HI3_ZERO);
                        end
                        default: bad = 1'b1;
                    endcase
                end
                `CBFA_F3_ADDN: op_sel = OP_NORM;
                `CBFA_F3_SUBN: op_sel = OP_NORM;
                default: bad = 1'b1;
            endcase
        end else if (opc == `CBFA_OPC_REG) begin
            claim = 1'b1;
            op_sel = OP_FIELD_REG;
            if (f3 != `CBFA_F3_REG) begin
                bad = 1'b1;
            end else begin
                case (f7)
                    `CBFA_F7_SEXT_R: fsel = `CBFA_FS_SEXT;
                    `CBFA_F7_ZEXT_R: fsel = `CBFA_FS_ZEXT;
                    `CBFA_F7_INS_R: fsel = `CBFA_FS_INS;
                    `CBFA_F7_CLR_R: fsel = `CBFA_FS_CLR;
                    `CBFA_F7_SET_R: fsel = `CBFA_FS_SET;
                    `CBFA_F7_ROR: op_sel = OP_ROR;
                    `CBFA_F7_FF1: op_sel = OP_FF1;
                    `CBFA_F7_FL1: op_sel = OP_FL1;
                    `CBFA_F7_CLB: op_sel = OP_CLB;
                    `CBFA_F7_CNT: op_sel = OP_CNT;
                    `CBFA_F7_ABS: op_sel = OP_ABS;
                    `CBFA_F7_SLE: op_sel = OP_SLE;
                    `CBFA_F7_SLEU: op_sel = OP_SLEU;
                    `CBFA_F7_MIN: op_sel = OP_MIN;
                    `CBFA_F7_MINU: op_sel = OP_MINU;
                    `CBFA_F7_MAX: op_sel = OP_MAX;
                    `CBFA_F7_MAXU: op_sel = OP_MAXU;
                    `CBFA_F7_EXTHS: op_sel = OP_EXTHS;
                    `CBFA_F7_EXTHZ: op_sel = OP_EXTHZ;
                    `CBFA_F7_EXTBS: op_sel = OP_EXTBS;
                    `CBFA_F7_EXTBZ: op_sel = OP_EXTBZ;
                    `CBFA_F7_CLIP: op_sel = OP_CLIP;
                    `CBFA_F7_CLIPU: op_sel = OP_CLIPU;
                    `CBFA_F7_CLIPR: op_sel = OP_CLIPR;
                    `CBFA_F7_CLIPUR: op_sel = OP_CLIPUR;
                    default: bad = 1'b1;
                endcase
                // single-source forms insist on a zero second field
                case (f7)
                    `CBFA_F7_FF1, `CBFA_F7_FL1, `CBFA_F7_CLB, `CBFA_F7_CNT,
                    `CBFA_F7_ABS, `CBFA_F7_EXTHS, `CBFA_F7_EXTHZ,
                    `CBFA_F7_EXTBS, `CBFA_F7_EXTBZ: begin
                        if (!rs2_zero) begin
                            bad = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ========
    // bit-field unit
    cbfa_field_unit u_field (
        .src_a(src_a),
        .src_d(src_d),
        .width_imm(op_sel == OP_FIELD_REG ? src_b[`CBFA_B_WIDTH] : imm_w),
        .offset_imm(op_sel == OP_FIELD_REG ? src_b[`CBFA_B_OFFS] : imm_o),
        .fsel(fsel),
        .result(field_res)
    );

    // ========
    // scan operations
    always @* begin
        ff1_cnt = `CBFA_NONE;
        fl1_cnt = `CBFA_NONE;
        pop_cnt = 6'h00;
        clb_cnt = 6'h00;
        clb_stop = 1'b0;
        for (k = 31; k >= 0; k = k - 1) begin
            if (src_a[k]) begin
                ff1_cnt = k[5:0];
            end
        end
        for (k = 0; k < 32; k = k + 1) begin
            if (src_a[k]) begin
                fl1_cnt = k[5:0];
                pop_cnt = pop_cnt + 6'h01;
            end
        end
        // counting from bit 30 yields the count minus one directly
        for (k = 30; k >= 0; k = k - 1) begin
            if (!clb_stop && (src_a[k] == src_a[31])) begin
                clb_cnt = clb_cnt + 6'h01;
            end else begin
                clb_stop = 1'b1;
            end
        end
        if (src_a == `CBFA_ZERO) begin
            clb_cnt = 6'h00;
        end
    end

    // ========
    // arithmetic helpers
    assign rot_dbl = {src_a, src_a} >> src_b[`CBFA_B_OFFS];
    assign lt_s = $signed(src_a) < $signed(src_b);
    assign lt_u = src_a < src_b;
    // (1 << n) >> 1 is 2^(n-1) and zero for n = 0
    assign clip_pow = (`CBFA_ONE << imm_o) >> 1;
    assign clip_hi = (clip_pow == `CBFA_ZERO) ? `CBFA_ZERO : clip_pow - `CBFA_ONE;
    assign rnd_term = sel2[1] ? ((`CBFA_ONE << imm_w) >> 1) : `CBFA_ZERO;
    // sums wrap at 32 bits before the shift
    assign norm_sum = (f3 == `CBFA_F3_SUBN) ? src_a - src_b + rnd_term
                                            : src_a + src_b + rnd_term;
    assign norm_res = sel2[0] ? norm_sum >> imm_w
                              : $unsigned($signed(norm_sum) >>> imm_w);

    // ========
    // result select
    always @* begin
        case (op_sel)
            OP_FIELD_IMM, OP_FIELD_REG: alu_res = field_res;
            OP_ROR: alu_res = rot_dbl[31:0];
            OP_FF1: alu_res = {26'h000_0000, ff1_cnt};
            OP_FL1: alu_res = {26'h000_0000, fl1_cnt};
            OP_CLB: alu_res = {26'h000_0000, clb_cnt};
            OP_CNT: alu_res = {26'h000_0000, pop_cnt};
            OP_ABS: alu_res = src_a[31] ? `CBFA_ZERO - src_a : src_a;
            OP_SLE: alu_res = (lt_s || src_a == src_b) ? `CBFA_ONE : `CBFA_ZERO;
            OP_SLEU: alu_res = (lt_u || src_a == src_b) ? `CBFA_ONE : `CBFA_ZERO;
            OP_MIN: alu_res = lt_s ? src_a : src_b;
            OP_MINU: alu_res = lt_u ? src_a : src_b;
            OP_MAX: alu_res = lt_s ? src_b : src_a;
            OP_MAXU: alu_res = lt_u ? src_b : src_a;
            OP_EXTHS: alu_res = {{16{src_a[15]}}, src_a[15:0]};
            OP_EXTHZ: alu_res = {16'h0000, src_a[15:0]};
            OP_EXTBS: alu_res = {{24{src_a[7]}}, src_a[7:0]};
            OP_EXTBZ: alu_res = {24'h00_0000, src_a[7:0]};
            OP_CLIP: begin
                if ($signed(src_a) <= $signed(~clip_hi)) begin
                    alu_res = ~clip_hi;
                end else if ($signed(src_a) >= $signed(clip_hi)) begin
                    alu_res = clip_hi;
                end else begin
                    alu_res = src_a;
                end
            end
            OP_CLIPU: begin
                if ($signed(src_a) <= $signed(`CBFA_ZERO)) begin
                    alu_res = `CBFA_ZERO;
                end else if ($signed(src_a) >= $signed(clip_hi)) begin
                    alu_res = clip_hi;
                end else begin
                    alu_res = src_a;
                end
            end
            OP_CLIPR: begin
                // -(b + 1) is the bitwise inverse of b
                if ($signed(src_a) <= $signed(~src_b)) begin
                    alu_res = ~src_b;
                end else if ($signed(src_a) >= $signed(src_b)) begin
                    alu_res = src_b;
                end else begin
                    alu_res = src_a;
                end
            end
            OP_CLIPUR: begin
                if ($signed(src_a) <= $signed(`CBFA_ZERO)) begin
                    alu_res = `CBFA_ZERO;
                end else if ($signed(src_a) >= $signed(src_b)) begin
                    alu_res = src_b;
                end else begin
                    alu_res = src_a;
                end
            end
            OP_NORM: alu_res = norm_res;
            default: alu_res = `CBFA_ZERO;
        endcase
    end

    // ========
    // output stage
    always @(posedge ref_clk) begin
        if (reset) begin
            result_valid_reg <= 1'b0;
            result_data_reg <= `CBFA_ZERO;
            illegal_reg <= 1'b0;
        end else begin
            result_valid_reg <= instr_valid && claim && !bad;
            // an illegal word never writes a result
            result_data_reg <= (instr_valid && claim && !bad) ? alu_res : `CBFA_ZERO;
            illegal_reg <= instr_valid && claim && bad;
        end
    end

    assign result_valid = result_valid_reg;
    assign result_data = result_data_reg;
    assign illegal_instr = illegal_reg;
endmodule

// File: tb/cbfa_alu_sva.sv
// port-level assertion checker for the custom alu
`timescale 1ns/10ps
`include "cbfa_alu_map.vh"

module cbfa_alu_sva (
    input wire ref_clk,
    input wire reset,
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire [31:0] src_a,
    input wire [31:0] src_b,
    input wire [31:0] src_d,
    input wire result_valid,
    input wire [31:0] result_data,
    input wire illegal_instr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ========
    // decode helpers
    reg [31:0] a_q;
    reg [31:0] b_q;
    wire [6:0] f7 = instr_word[`CBFA_F_F7];
    wire [6:0] opc = instr_word[`CBFA_F_OPC];
    wire ours = (opc == `CBFA_OPC_IMM) || (opc == `CBFA_OPC_REG);
    wire grp = instr_valid && opc == `CBFA_OPC_REG && instr_word[`CBFA_F_F3] == `CBFA_F3_REG;
    wire solo = grp && instr_word[`CBFA_F_RS2] == `CBFA_RS2_ZERO;
    // operands one cycle back, to compare against the registered result
    always @(posedge ref_clk) begin
        a_q <= src_a;
        b_q <= src_b;
    end
    // ========
    // properties
    property p_one_kind;
        !(result_valid && illegal_instr);
    endproperty
    a_one_kind: assert property (p_one_kind) else $error("result and illegal together");
    property p_idle_zero;
        !result_valid |-> result_data == `CBFA_ZERO;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data not zero while idle");
    property p_cause;
        result_valid || illegal_instr |-> $past(instr_valid);
    endproperty
    a_cause: assert property (p_cause) else $error("output without request");
    property p_foreign;
        instr_valid && !ours |=> !result_valid && !illegal_instr;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign opcode answered");
    property p_abs;
        solo && f7 == `CBFA_F7_ABS |=> result_valid && result_data == (a_q[31] ? -a_q : a_q);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute value wrong");
    property p_sle;
        grp && f7 == `CBFA_F7_SLE
            |=> result_data == (($signed(a_q) <= $signed(b_q)) ? `CBFA_ONE : `CBFA_ZERO);
    endproperty
    a_sle: assert property (p_sle) else $error("signed less-or-equal wrong");
    property p_minu;
        grp && f7 == `CBFA_F7_MINU |=> result_data == ((a_q < b_q) ? a_q : b_q);
    endproperty
    a_minu: assert property (p_minu) else $error("unsigned minimum wrong");
    property p_max;
        grp && f7 == `CBFA_F7_MAX |=> result_data == (($signed(a_q) < $signed(b_q)) ? b_q : a_q);
    endproperty
    a_max: assert property (p_max) else $error("signed maximum wrong");
    property p_exths;
        solo && f7 == `CBFA_F7_EXTHS |=> result_data == {{16{a_q[15]}}, a_q[15:0]};
    endproperty
    a_exths: assert property (p_exths) else $error("half-word sign extend wrong");
    property p_bad_f3;
        instr_valid && opc == `CBFA_OPC_IMM && instr_word[14] |=> illegal_instr && !result_valid;
    endproperty
    a_bad_f3: assert property (p_bad_f3) else $error("undefined funct3 not flagged");
    property p_clipur;
        grp && f7 == `CBFA_F7_CLIPUR && $signed(src_a) <= 0 |=> result_data == `CBFA_ZERO;
    endproperty
    a_clipur: assert property (p_clipur) else $error("unsigned clip of non-positive");
    c_abs: cover property (solo && f7 == `CBFA_F7_ABS);
    c_bad: cover property (illegal_instr);
    c_clipur: cover property (grp && f7 == `CBFA_F7_CLIPUR);
endmodule

bind cbfa_alu cbfa_alu_sva cbfa_alu_sva_i (.ref_clk(ref_clk), .reset(reset),
    .instr_valid(instr_valid), .instr_word(instr_word), .src_a(src_a), .src_b(src_b),
    .src_d(src_d), .result_valid(result_valid), .result_data(result_data),
    .illegal_instr(illegal_instr));

// File: tb/cbfa_core_model.sv
// decode-stage model: issues words and operands, captures the answer
`timescale 1ns/10ps

module cbfa_core_model (
    input wire ref_clk,
    output reg instr_valid,
    output reg [31:0] instr_word,
    output reg [31:0] src_a,
    output reg [31:0] src_b,
    output reg [31:0] src_d,
    input wire result_valid,
    input wire [31:0] result_data,
    input wire illegal_instr
);
    reg got_v;
    reg got_i;
    reg [31:0] got_d;
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'h0000_0000;
        src_a = 32'h0000_0000;
        src_b = 32'h0000_0000;
        src_d = 32'h0000_0000;
    end
    // call at a falling edge; answer one cycle later
    task xfer(input [31:0] w, a, b, d);
        instr_valid = 1'b1;
        instr_word = w;
        src_a = a;
        src_b = b;
        src_d = d;
        @(negedge ref_clk);
        got_v = result_valid;
        got_i = illegal_instr;
        got_d = result_data;
    endtask
    // released lines show the inverse, never stale values
    task idle;
        instr_valid = 1'b0;
        instr_word = ~instr_word;
        src_a = ~src_a;
        src_b = ~src_b;
        src_d = ~src_d;
    endtask
endmodule

// File: tb/cbfa_alu_tb.sv
// self-checking testbench for the custom alu
`timescale 1ns/10ps
`include "cbfa_alu_map.vh"
`define CHK(g, e) begin checks_done = checks_done + 1; if ((g) !== (e)) begin \
    err_total = err_total + 1; $display("BAD %0t got %h exp %h", $time, g, e); end end

module testbench;
    reg ref_clk;
    reg reset;
    wire instr_valid, result_valid, illegal_instr;
    wire [31:0] instr_word, src_a, src_b, src_d, result_data;
    integer err_total;
    integer checks_done;
    always #5 ref_clk = ~ref_clk;
    cbfa_alu cbfa_alu_i (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
        .instr_word(instr_word), .src_a(src_a), .src_b(src_b), .src_d(src_d),
        .result_valid(result_valid), .result_data(result_data), .illegal_instr(illegal_instr));
    cbfa_core_model cbfa_core_model_i (.ref_clk(ref_clk), .instr_valid(instr_valid),
        .instr_word(instr_word), .src_a(src_a), .src_b(src_b), .src_d(src_d),
        .result_valid(result_valid), .result_data(result_data), .illegal_instr(illegal_instr));
    // ========
    // word builders and transfer checks
    function [31:0] wi(input [1:0] s, input [4:0] w, input [4:0] o, input [2:0] f);
        wi = {s, w, o, 5'h01, f, 5'h02, `CBFA_OPC_IMM};
    endfunction
    function [31:0] wr(input [6:0] f7, input [4:0] r2);
        wr = {f7, r2, 5'h01, `CBFA_F3_REG, 5'h02, `CBFA_OPC_REG};
    endfunction
    task op(input [31:0] w, a, b, d, e);
        cbfa_core_model_i.xfer(w, a, b, d);
        `CHK(cbfa_core_model_i.got_v, 1'b1)
        `CHK(cbfa_core_model_i.got_i, 1'b0)
        `CHK(cbfa_core_model_i.got_d, e)
    endtask
    task bad(input [31:0] w, input flag);
        cbfa_core_model_i.xfer(w, 32'hFFFF_FFFF, 32'h0000_0065, `CBFA_ZERO);
        `CHK(cbfa_core_model_i.got_v, 1'b0)
        `CHK(cbfa_core_model_i.got_i, flag)
        `CHK(cbfa_core_model_i.got_d, `CBFA_ZERO)
    endtask
    task done(input [79:0] name);
        cbfa_core_model_i.idle;
        @(negedge ref_clk);
        $display("test %0s done", name);
    endtask
    // ========
    // scenarios
    task t_field;
        op(wi(2'h0, 5'h03, 5'h05, `CBFA_F3_EXTINS), 32'h0000_0B60, 0, 0, 32'hFFFF_FFFB);
        op(wi(2'h1, 5'h03, 5'h05, `CBFA_F3_EXTINS), 32'h0000_0B60, 0, 0, 32'h0000_000B);
        op(wi(2'h2, 5'h03, 5'h05, `CBFA_F3_EXTINS), 32'h0000_0B60, 0, -1, 32'hFFFF_FE1F);
        op(wi(2'h0, 5'h03, 5'h05, `CBFA_F3_CLRSET), -1, 0, 0, 32'hFFFF_FE1F);
        op(wi(2'h1, 5'h03, 5'h05, `CBFA_F3_CLRSET), 0, 0, 0, 32'h0000_01E0);
        op(wi(2'h3, 5'h02, 5'h04, `CBFA_F3_CLRSET), 32'hC64A_5933, 0, 0, 32'h216B_244B);
        op(wi(2'h3, 5'h01, 5'h00, `CBFA_F3_CLRSET), 1, 0, 0, 32'h4000_0000);
        op(wi(2'h3, 5'h03, 5'h00, `CBFA_F3_CLRSET), 1, 0, 0, 32'h8000_0000);
        op(wr(`CBFA_F7_SEXT_R, 5'h03), 32'h0000_0B60, 32'h0000_0065, 0, 32'hFFFF_FFFB);
        op(wr(`CBFA_F7_ZEXT_R, 5'h03), 32'h0000_0B60, 32'h0000_0065, 0, 32'h0000_000B);
        op(wr(`CBFA_F7_INS_R, 5'h03), 32'h0000_0B60, 32'h0000_0065, -1, 32'hFFFF_FE1F);
        op(wr(`CBFA_F7_CLR_R, 5'h03), -1, 32'h0000_0065, 0, 32'hFFFF_FE1F);
        op(wr(`CBFA_F7_SET_R, 5'h03), 0, 32'h0000_0065, 0, 32'h0000_01E0);
        done("field");
    endtask
    task t_bits;
        op(wr(`CBFA_F7_ROR, 5'h03), 1, 1, 0, 32'h8000_0000);
        op(wr(`CBFA_F7_FF1, 5'h00), 32'h0000_0100, 0, 0, 32'h0000_0008);
        op(wr(`CBFA_F7_FF1, 5'h00), 0, 0, 0, 32'h0000_0020);
        op(wr(`CBFA_F7_FL1, 5'h00), 32'h8000_0000, 0, 0, 32'h0000_001F);
        op(wr(`CBFA_F7_FL1, 5'h00), 1, 0, 0, `CBFA_ZERO);
        op(wr(`CBFA_F7_FL1, 5'h00), 0, 0, 0, 32'h0000_0020);
        op(wr(`CBFA_F7_CLB, 5'h00), 32'h0000_0F00, 0, 0, 32'h0000_0013);
        op(wr(`CBFA_F7_CNT, 5'h00), 32'hF0F0_0001, 0, 0, 32'h0000_0009);
        done("bits");
    endtask
    task t_gen;
        op(wr(`CBFA_F7_ABS, 5'h00), 32'hFFFF_FFFB, 0, 0, 32'h0000_0005);
        op(wr(`CBFA_F7_SLE, 5'h03), -1, 1, 0, `CBFA_ONE);
        op(wr(`CBFA_F7_SLEU, 5'h03), -1, 1, 0, `CBFA_ZERO);
        op(wr(`CBFA_F7_MIN, 5'h03), -1, 1, 0, 32'hFFFF_FFFF);
        op(wr(`CBFA_F7_MINU, 5'h03), -1, 1, 0, `CBFA_ONE);
        op(wr(`CBFA_F7_MAX, 5'h03), -1, 1, 0, `CBFA_ONE);
        op(wr(`CBFA_F7_MAXU, 5'h03), -1, 1, 0, 32'hFFFF_FFFF);
        op(wr(`CBFA_F7_EXTHS, 5'h00), 32'h1234_8001, 0, 0, 32'hFFFF_8001);
        op(wr(`CBFA_F7_EXTHZ, 5'h00), 32'h1234_8001, 0, 0, 32'h0000_8001);
        op(wr(`CBFA_F7_EXTBS, 5'h00), 32'h0000_0180, 0, 0, 32'hFFFF_FF80);
        op(wr(`CBFA_F7_EXTBZ, 5'h00), 32'h0000_0180, 0, 0, 32'h0000_0080);
        done("general");
    endtask
    task t_clip;
        op(wr(`CBFA_F7_CLIP, 5'h04), 32'h0000_0064, 0, 0, 32'h0000_0007);
        op(wr(`CBFA_F7_CLIP, 5'h04), 32'hFFFF_FF9C, 0, 0, 32'hFFFF_FFF8);
        op(wr(`CBFA_F7_CLIP, 5'h04), 32'h0000_0003, 0, 0, 32'h0000_0003);
        op(wr(`CBFA_F7_CLIP, 5'h00), 32'h0000_0005, 0, 0, `CBFA_ZERO);
        op(wr(`CBFA_F7_CLIP, 5'h00), 32'hFFFF_FFFB, 0, 0, 32'hFFFF_FFFF);
        op(wr(`CBFA_F7_CLIPU, 5'h04), 32'hFFFF_FFFD, 0, 0, `CBFA_ZERO);
        op(wr(`CBFA_F7_CLIPU, 5'h04), 32'h0000_0064, 0, 0, 32'h0000_0007);
        op(wr(`CBFA_F7_CLIPU, 5'h00), 32'h0000_0005, 0, 0, `CBFA_ZERO);
        op(wr(`CBFA_F7_CLIPR, 5'h03), 32'hFFFF_FF9C, 7, 0, 32'hFFFF_FFF8);
        op(wr(`CBFA_F7_CLIPR, 5'h03), 32'h0000_0064, 7, 0, 32'h0000_0007);
        op(wr(`CBFA_F7_CLIPUR, 5'h03), -1, 7, 0, `CBFA_ZERO);
        op(wr(`CBFA_F7_CLIPUR, 5'h03), 32'h0000_0009, 7, 0, 32'h0000_0007);
        done("clip");
    endtask
    task t_norm;
        op(wi(2'h0, 5'h02, 5'h03, `CBFA_F3_ADDN), -16, -9, 0, 32'hFFFF_FFF9);
        op(wi(2'h1, 5'h02, 5'h03, `CBFA_F3_ADDN), -16, -9, 0, 32'h3FFF_FFF9);
        op(wi(2'h2, 5'h02, 5'h03, `CBFA_F3_ADDN), -16, -9, 0, 32'hFFFF_FFFA);
        op(wi(2'h3, 5'h02, 5'h03, `CBFA_F3_ADDN), -16, -9, 0, 32'h3FFF_FFFA);
        op(wi(2'h2, 5'h00, 5'h03, `CBFA_F3_ADDN), -16, -9, 0, 32'hFFFF_FFE7);
        op(wi(2'h0, 5'h01, 5'h03, `CBFA_F3_SUBN), 5, 12, 0, 32'hFFFF_FFFC);
        op(wi(2'h1, 5'h01, 5'h03, `CBFA_F3_SUBN), 5, 12, 0, 32'h7FFF_FFFC);
        op(wi(2'h2, 5'h01, 5'h03, `CBFA_F3_SUBN), 5, 12, 0, 32'hFFFF_FFFD);
        op(wi(2'h3, 5'h01, 5'h03, `CBFA_F3_SUBN), 5, 12, 0, 32'h7FFF_FFFD);
        op(wi(2'h3, 5'h00, 5'h03, `CBFA_F3_SUBN), 5, 12, 0, 32'hFFFF_FFF9);
        done("normalise");
    endtask
    task t_illegal;
        bad(wi(2'h3, 5'h00, 5'h00, `CBFA_F3_EXTINS), 1'b1);
        bad(wi(2'h2, 5'h00, 5'h00, `CBFA_F3_CLRSET), 1'b1);
        bad(wi(2'h3, 5'h06, 5'h00, `CBFA_F3_CLRSET), 1'b1);
        bad(wi(2'h0, 5'h00, 5'h00, 3'h4), 1'b1);
        bad(wr(`CBFA_F7_SEXT_R, 5'h01) & 32'hFFFF_8FFF, 1'b1);
        bad(wr(7'h40, 5'h01), 1'b1);
        bad(wr(`CBFA_F7_FF1, 5'h01), 1'b1);
        bad(32'h0000_0033, 1'b0);
        done("illegal");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ========
    // main sequence and watchdog
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        err_total = 0;
        checks_done = 0;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        `CHK(result_valid, 1'b0)
        `CHK(result_data, `CBFA_ZERO)
        t_field;
        t_bits;
        t_gen;
        t_clip;
        t_norm;
        t_illegal;
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_total = err_total + 1;
        stop_test;
    end
endmodule
